/* File: hvr_pkg.sv */
// hvr_pkg: register map, reset values, timing counts and types for the
// haptic segment-timing and audio-to-vibe configuration block.
// assumes a 10 MHz system clock; all users import the whole package.
`default_nettype none

package hvr_pkg;
  localparam logic [7:0] ADDR_POS_OFF = 8'h0e;
  localparam logic [7:0] ADDR_NEG_OFF = 8'h0f;
  localparam logic [7:0] ADDR_BRK_OFF = 8'h10;
  localparam logic [7:0] ADDR_A2V_CTL = 8'h11;
  localparam logic [7:0] ADDR_IN_FLOOR = 8'h12;
  localparam logic [7:0] ADDR_IN_FULL = 8'h13;
  localparam logic [7:0] ADDR_DRV_FLOOR = 8'h14;

  localparam logic [7:0] RST_OFFSET = 8'h00;
  localparam logic [1:0] RST_PEAK_WIN = 2'h1;
  localparam logic [1:0] RST_LP_SEL = 2'h1;
  localparam logic [7:0] RST_IN_FLOOR = 8'h19;
  localparam logic [7:0] RST_IN_FULL = 8'hff;
  localparam logic [7:0] RST_DRV_FLOOR = 8'h19;

  localparam int CTL_PEAK_LSB = 2;
  localparam int CTL_LP_LSB = 0;
  localparam logic [7:0] CODE_FULL = 8'hff;
  localparam logic [3:0] DIV_STEPS = 4'h8;

  localparam int CLK_KHZ = 10000;
  localparam int STEP_MS = 5;
  localparam int STEP_CYC_DFLT = STEP_MS * CLK_KHZ;
  localparam int PEAK_UNIT_MS = 10;
  localparam int PEAK_UNIT_CYC_DFLT = PEAK_UNIT_MS * CLK_KHZ;
  localparam int CNT_W = 20;

  typedef enum logic [2:0] {SEG_IDLE, SEG_OVERDRIVE, SEG_POS_SUSTAIN, SEG_NEG_SUSTAIN, SEG_BRAKE} hvr_seg_class_t;
endpackage : hvr_pkg

`default_nettype wire

/* File: hvr_cfg_if.sv */
// hvr_cfg_if: configuration values handed from the register file (drive ceiling from a port) to the
// segment adjuster and the audio-to-vibe shaper; no clock of its own.
`default_nettype none

interface hvr_cfg_if;
  logic signed [7:0] pos_off;
  logic signed [7:0] neg_off;
  logic signed [7:0] brk_off;
  logic [7:0] in_floor;
  logic [7:0] in_full;
  logic [7:0] drv_floor;
  logic [7:0] drv_ceil;
  modport src (output pos_off, neg_off, brk_off, in_floor, in_full, drv_floor, drv_ceil);
  modport seg (input pos_off, neg_off, brk_off);
  modport a2v (input in_floor, in_full, drv_floor, drv_ceil);
endinterface : hvr_cfg_if

`default_nettype wire

/* File: hvr_seg_adjust.sv */
// hvr_seg_adjust: classifies one library waveform segment and applies the
// signed step offset to its duration, one cycle after seg_start.
// assumes the playback engine supplies the waveform's extreme levels.
`default_nettype none

module hvr_seg_adjust import hvr_pkg::*;
(
  input wire logic mclk, // system clock
  input wire logic rst_b, // sync reset, active low
  hvr_cfg_if.seg cfg, // offsets
  input wire logic seg_start, // segment presented
  input wire logic signed [7:0] seg_level, // segment drive level
  input wire logic [7:0] seg_dur, // stored duration, steps
  input wire logic signed [7:0] wave_max, // highest level of waveform
  input wire logic signed [7:0] wave_min, // lowest level of waveform
  input wire logic closed_loop, // closed-loop operation
  output logic adj_valid, // result pulse
  output hvr_seg_class_t adj_class, // segment kind
  output logic [8:0] adj_steps // adjusted duration, steps
);
  hvr_seg_class_t cls;
  logic signed [7:0] off;
  logic signed [9:0] sum;
  logic valid_nxt;
  hvr_seg_class_t class_nxt;
  logic [8:0] steps_nxt;

  always_comb
  begin
    cls = SEG_IDLE;
    if (seg_level > 0 && seg_level == wave_max)
      cls = SEG_OVERDRIVE;
    else if (seg_level < 0 && seg_level == wave_min)
      cls = SEG_BRAKE;
    else if (seg_level > 0)
      cls = SEG_POS_SUSTAIN;
    else if (seg_level < 0)
      cls = SEG_NEG_SUSTAIN;
    unique case (cls)
      SEG_POS_SUSTAIN: off = cfg.pos_off;
      SEG_NEG_SUSTAIN: off = cfg.neg_off;
      SEG_BRAKE: off = closed_loop ? 8'sh00 : cfg.brk_off;
      default: off = 8'sh00;
    endcase
    sum = $signed({2'b00, seg_dur}) + $signed({{2{off[7]}}, off});
    valid_nxt = seg_start;
    class_nxt = seg_start ? cls : adj_class;
    // negative overrun clamps instead of wrapping to a huge duration
    steps_nxt = seg_start ? ((sum < 0) ? 9'h000 : sum[8:0]) : adj_steps;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      adj_valid <= 1'b0;
      adj_class <= SEG_IDLE;
      adj_steps <= 9'h000;
    end
    else
    begin
      adj_valid <= valid_nxt;
      adj_class <= class_nxt;
      adj_steps <= steps_nxt;
    end
  end

  chk_pos_offset_add: assert property (@(posedge mclk) disable iff (!rst_b)
    seg_start && seg_level > 0 && seg_level != wave_max && !cfg.pos_off[7]
    |=> adj_class == SEG_POS_SUSTAIN && adj_steps == 9'($past(seg_dur)) + 9'($past(cfg.pos_off)))
    else $error("positive sustain offset not added");

  chk_brake_closed: assert property (@(posedge mclk) disable iff (!rst_b)
    seg_start && closed_loop && seg_level < 0 && seg_level == wave_min
    |=> adj_class == SEG_BRAKE && adj_steps == {1'b0, $past(seg_dur)})
    else $error("brake offset applied in closed loop");

  chk_clamp_zero: assert property (@(posedge mclk) disable iff (!rst_b)
    seg_start && seg_level < 0 && seg_level != wave_min
    && $signed({2'b00, seg_dur}) + $signed({{2{cfg.neg_off[7]}}, cfg.neg_off}) < 0
    |=> adj_valid && adj_steps == 9'h000)
    else $error("negative overrun not clamped at zero");
endmodule : hvr_seg_adjust

`default_nettype wire

/* File: hvr_a2v_shape.sv */
// hvr_a2v_shape: maps one peak code to 0 below the input floor, else to a drive level
// between the floor and the ceiling, scaled against the full-scale input; 8-cycle divider.
// assumes peak codes arrive no faster than one per ten cycles.
`default_nettype none

module hvr_a2v_shape import hvr_pkg::*;
(
  input wire logic mclk, // system clock
  input wire logic rst_b, // sync reset, active low
  hvr_cfg_if.a2v cfg, // input and drive limits
  input wire logic peak_valid, // peak code pulse
  input wire logic [7:0] peak_code, // peak amplitude code
  output logic drive_valid, // drive result pulse
  output logic [7:0] drive // drive level code
);
  typedef enum logic {SH_IDLE, SH_DIV} hvr_sh_state_t;
  hvr_sh_state_t st_r, st_nxt;
  logic [7:0] rem_r, rem_nxt, num_r, num_nxt, q_r, q_nxt, drive_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic valid_nxt;
  logic [8:0] trial;
  logic [15:0] prod;

  function automatic logic [7:0] limit(input logic [7:0] q, input logic [7:0] lo, input logic [7:0] hi);
    logic [7:0] v;
    v = (q < lo) ? lo : q;
    limit = (v > hi) ? hi : v;
  endfunction : limit

  always_comb
  begin
    st_nxt = st_r;
    rem_nxt = rem_r;
    num_nxt = num_r;
    q_nxt = q_r;
    cnt_nxt = cnt_r;
    valid_nxt = 1'b0;
    drive_nxt = drive;
    prod = 16'(peak_code * CODE_FULL);
    trial = {rem_r, num_r[7]};
    unique case (st_r)
      SH_IDLE:
        if (peak_valid)
        begin
          if (peak_code < cfg.in_floor)
          begin
            valid_nxt = 1'b1;
            drive_nxt = 8'h00;
          end
          else if (peak_code >= cfg.in_full)
          begin
            valid_nxt = 1'b1;
            drive_nxt = limit(CODE_FULL, cfg.drv_floor, cfg.drv_ceil);
          end
          else
          begin
            // high byte already below divisor, so 8 quotient bits suffice
            rem_nxt = prod[15:8];
            num_nxt = prod[7:0];
            cnt_nxt = DIV_STEPS;
            st_nxt = SH_DIV;
          end
        end
      SH_DIV:
      begin
        num_nxt = {num_r[6:0], 1'b0};
        if (trial >= {1'b0, cfg.in_full})
        begin
          rem_nxt = 8'(trial - {1'b0, cfg.in_full});
          q_nxt = {q_r[6:0], 1'b1};
        end
        else
        begin
          rem_nxt = trial[7:0];
          q_nxt = {q_r[6:0], 1'b0};
        end
        cnt_nxt = cnt_r - 4'h1;
        if (cnt_r == 4'h1)
        begin
          valid_nxt = 1'b1;
          drive_nxt = limit(q_nxt, cfg.drv_floor, cfg.drv_ceil);
          st_nxt = SH_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      st_r <= SH_IDLE;
      rem_r <= 8'h00;
      num_r <= 8'h00;
      q_r <= 8'h00;
      cnt_r <= 4'h0;
      drive_valid <= 1'b0;
      drive <= 8'h00;
    end
    else
    begin
      st_r <= st_nxt;
      rem_r <= rem_nxt;
      num_r <= num_nxt;
      q_r <= q_nxt;
      cnt_r <= cnt_nxt;
      drive_valid <= valid_nxt;
      drive <= drive_nxt;
    end
  end

  chk_input_ignore: assert property (@(posedge mclk) disable iff (!rst_b)
    st_r == SH_IDLE && peak_valid && peak_code < cfg.in_floor |=> drive_valid && drive == 8'h00)
    else $error("sub-threshold input produced drive");

  chk_fullscale_drive: assert property (@(posedge mclk) disable iff (!rst_b)
    st_r == SH_IDLE && peak_valid && peak_code >= cfg.in_full && peak_code >= cfg.in_floor
    && cfg.drv_floor <= cfg.drv_ceil |=> drive_valid && drive == $past(cfg.drv_ceil))
    else $error("full-scale input not at ceiling");

  chk_drive_floor: assert property (@(posedge mclk) disable iff (!rst_b)
    drive_valid && drive != 8'h00 && cfg.drv_floor <= cfg.drv_ceil |-> drive >= cfg.drv_floor)
    else $error("drive below minimum level");

  chk_drive_ceiling: assert property (@(posedge mclk) disable iff (!rst_b)
    st_r == SH_DIV && cnt_r == 4'h1 |=> drive_valid && drive <= $past(cfg.drv_ceil))
    else $error("drive above maximum level");
endmodule : hvr_a2v_shape

`default_nettype wire

/* File: hvr_timing_a2v_regs.sv */
// hvr_timing_a2v_regs: segment-timing offset and audio-to-vibe registers of a
// haptic driver, a segment step timer and the audio peak window tracker.
// assumes a byte register port from the serial decoder, one cycle per access.
`default_nettype none

module hvr_timing_a2v_regs import hvr_pkg::*;
#(
  parameter int STEP_CYC = STEP_CYC_DFLT,
  parameter int PEAK_UNIT_CYC = PEAK_UNIT_CYC_DFLT
)
(
  input wire logic mclk, // system clock
  input wire logic rst_b, // sync reset, active low
  input wire logic [7:0] reg_addr, // register address
  input wire logic reg_wr, // write strobe
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_rd, // read strobe
  output logic [7:0] reg_rdata, // read data, next cycle
  input wire logic seg_start, // segment presented
  input wire logic signed [7:0] seg_level, // segment drive level
  input wire logic [7:0] seg_dur, // stored duration, steps
  input wire logic signed [7:0] wave_max, // highest level of waveform
  input wire logic signed [7:0] wave_min, // lowest level of waveform
  input wire logic closed_loop, // closed-loop operation
  output logic seg_busy, // segment timing running
  output logic seg_done, // segment end pulse
  output hvr_seg_class_t seg_class, // kind of current segment
  output logic [8:0] seg_steps, // adjusted duration, steps
  input wire logic a2v_mode, // audio-to-vibe active
  input wire logic audio_valid, // audio sample strobe
  input wire logic [7:0] audio_code, // audio amplitude code
  input wire logic [7:0] a2v_drive_ceiling, // drive cap code
  output logic a2v_drive_valid, // drive result pulse
  output logic [7:0] a2v_drive, // drive level code
  output logic [1:0] a2v_peak_window, // peak window select
  output logic [1:0] a2v_lowpass_sel // low-pass corner select
);
  hvr_cfg_if cfg();

  // register file
  logic signed [7:0] pos_off_r, pos_off_nxt, neg_off_r, neg_off_nxt, brk_off_r, brk_off_nxt;
  logic [1:0] peak_win_r, peak_win_nxt, lp_sel_r, lp_sel_nxt;
  logic [7:0] in_floor_r, in_floor_nxt, in_full_r, in_full_nxt, drv_floor_r, drv_floor_nxt;
  logic [7:0] rdata_r, rdata_nxt;

  always_comb
  begin
    pos_off_nxt = pos_off_r;
    neg_off_nxt = neg_off_r;
    brk_off_nxt = brk_off_r;
    peak_win_nxt = peak_win_r;
    lp_sel_nxt = lp_sel_r;
    in_floor_nxt = in_floor_r;
    in_full_nxt = in_full_r;
    drv_floor_nxt = drv_floor_r;
    rdata_nxt = rdata_r;
    if (reg_wr)
    begin
      unique case (reg_addr)
        ADDR_POS_OFF: pos_off_nxt = reg_wdata;
        ADDR_NEG_OFF: neg_off_nxt = reg_wdata;
        ADDR_BRK_OFF: brk_off_nxt = reg_wdata;
        ADDR_A2V_CTL:
        begin
          peak_win_nxt = reg_wdata[CTL_PEAK_LSB +: 2];
          lp_sel_nxt = reg_wdata[CTL_LP_LSB +: 2];
        end
        ADDR_IN_FLOOR: in_floor_nxt = reg_wdata;
        ADDR_IN_FULL: in_full_nxt = reg_wdata;
        ADDR_DRV_FLOOR: drv_floor_nxt = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd)
    begin
      unique case (reg_addr)
        ADDR_POS_OFF: rdata_nxt = pos_off_r;
        ADDR_NEG_OFF: rdata_nxt = neg_off_r;
        ADDR_BRK_OFF: rdata_nxt = brk_off_r;
        ADDR_A2V_CTL: rdata_nxt = {4'h0, peak_win_r, lp_sel_r};
        ADDR_IN_FLOOR: rdata_nxt = in_floor_r;
        ADDR_IN_FULL: rdata_nxt = in_full_r;
        ADDR_DRV_FLOOR: rdata_nxt = drv_floor_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      pos_off_r <= RST_OFFSET;
      neg_off_r <= RST_OFFSET;
      brk_off_r <= RST_OFFSET;
      peak_win_r <= RST_PEAK_WIN;
      lp_sel_r <= RST_LP_SEL;
      in_floor_r <= RST_IN_FLOOR;
      in_full_r <= RST_IN_FULL;
      drv_floor_r <= RST_DRV_FLOOR;
      rdata_r <= 8'h00;
    end
    else
    begin
      pos_off_r <= pos_off_nxt;
      neg_off_r <= neg_off_nxt;
      brk_off_r <= brk_off_nxt;
      peak_win_r <= peak_win_nxt;
      lp_sel_r <= lp_sel_nxt;
      in_floor_r <= in_floor_nxt;
      in_full_r <= in_full_nxt;
      drv_floor_r <= drv_floor_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign a2v_peak_window = peak_win_r;
  assign a2v_lowpass_sel = lp_sel_r;
  assign cfg.pos_off = pos_off_r;
  assign cfg.neg_off = neg_off_r;
  assign cfg.brk_off = brk_off_r;
  assign cfg.in_floor = in_floor_r;
  assign cfg.in_full = in_full_r;
  assign cfg.drv_floor = drv_floor_r;
  assign cfg.drv_ceil = a2v_drive_ceiling;

  // segment step timer
  logic adj_valid;
  hvr_seg_class_t adj_class;
  logic [8:0] adj_steps;

  hvr_seg_adjust u_adjust (
    .mclk(mclk),
    .rst_b(rst_b),
    .cfg(cfg.seg),
    .seg_start(seg_start),
    .seg_level(seg_level),
    .seg_dur(seg_dur),
    .wave_max(wave_max),
    .wave_min(wave_min),
    .closed_loop(closed_loop),
    .adj_valid(adj_valid),
    .adj_class(adj_class),
    .adj_steps(adj_steps)
  );

  localparam logic [CNT_W-1:0] STEP_LAST = CNT_W'(STEP_CYC - 1);
  logic busy_r, busy_nxt, done_r, done_nxt;
  hvr_seg_class_t cls_r, cls_nxt;
  logic [8:0] steps_r, steps_nxt, remain_r, remain_nxt;
  logic [CNT_W-1:0] tick_r, tick_nxt;

  always_comb
  begin
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    cls_nxt = cls_r;
    steps_nxt = steps_r;
    remain_nxt = remain_r;
    tick_nxt = tick_r;
    if (adj_valid)
    begin
      // a new segment aborts any segment still being timed
      cls_nxt = adj_class;
      steps_nxt = adj_steps;
      remain_nxt = adj_steps;
      tick_nxt = STEP_LAST;
      busy_nxt = (adj_steps != 9'h000);
      done_nxt = (adj_steps == 9'h000);
    end
    else if (busy_r)
    begin
      if (tick_r == '0)
      begin
        tick_nxt = STEP_LAST;
        remain_nxt = remain_r - 9'h001;
        if (remain_r == 9'h001)
        begin
          busy_nxt = 1'b0;
          done_nxt = 1'b1;
        end
      end
      else
        tick_nxt = tick_r - CNT_W'(1);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      cls_r <= SEG_IDLE;
      steps_r <= 9'h000;
      remain_r <= 9'h000;
      tick_r <= '0;
    end
    else
    begin
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      cls_r <= cls_nxt;
      steps_r <= steps_nxt;
      remain_r <= remain_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign seg_busy = busy_r;
  assign seg_done = done_r;
  assign seg_class = cls_r;
  assign seg_steps = steps_r;

  // audio peak window
  logic [CNT_W-1:0] win_r, win_nxt, win_last;
  logic [7:0] pk_r, pk_nxt, pk_out_r, pk_out_nxt;
  logic pk_valid_r, pk_valid_nxt;

  always_comb
  begin
    win_last = CNT_W'(PEAK_UNIT_CYC * (int'(peak_win_r) + 1) - 1);
    win_nxt = win_r;
    pk_nxt = pk_r;
    pk_out_nxt = pk_out_r;
    pk_valid_nxt = 1'b0;
    if (!a2v_mode)
    begin
      win_nxt = win_last;
      pk_nxt = 8'h00;
    end
    else
    begin
      if (audio_valid && audio_code > pk_r)
        pk_nxt = audio_code;
      if (win_r == '0)
      begin
        // window length changes take effect at the next window
        win_nxt = win_last;
        pk_valid_nxt = 1'b1;
        pk_out_nxt = pk_nxt;
        pk_nxt = 8'h00;
      end
      else
        win_nxt = win_r - CNT_W'(1);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      win_r <= '0;
      pk_r <= 8'h00;
      pk_out_r <= 8'h00;
      pk_valid_r <= 1'b0;
    end
    else
    begin
      win_r <= win_nxt;
      pk_r <= pk_nxt;
      pk_out_r <= pk_out_nxt;
      pk_valid_r <= pk_valid_nxt;
    end
  end

  hvr_a2v_shape u_shape (
    .mclk(mclk),
    .rst_b(rst_b),
    .cfg(cfg.a2v),
    .peak_valid(pk_valid_r),
    .peak_code(pk_out_r),
    .drive_valid(a2v_drive_valid),
    .drive(a2v_drive)
  );

  // helper: busy cycles of the current segment
  int busy_cyc_r;
  always_ff @(posedge mclk)
  begin
    if (!rst_b || adj_valid)
      busy_cyc_r <= 0;
    else if (busy_r)
      busy_cyc_r <= busy_cyc_r + 1;
  end

  chk_offset_reset: assert property (@(posedge mclk) disable iff (!rst_b)
    !$past(rst_b) |-> pos_off_r == RST_OFFSET && neg_off_r == RST_OFFSET && brk_off_r == RST_OFFSET)
    else $error("offsets not zero after reset");

  chk_ctl_reset: assert property (@(posedge mclk) disable iff (!rst_b)
    !$past(rst_b) |-> a2v_peak_window == RST_PEAK_WIN && a2v_lowpass_sel == RST_LP_SEL
    && in_floor_r == RST_IN_FLOOR && in_full_r == RST_IN_FULL && drv_floor_r == RST_DRV_FLOOR)
    else $error("audio settings wrong after reset");

  chk_seg_length: assert property (@(posedge mclk) disable iff (!rst_b)
    seg_done && $past(busy_r) |-> busy_cyc_r == int'(seg_steps) * STEP_CYC)
    else $error("segment length not steps times step period");

  chk_window_load: assert property (@(posedge mclk) disable iff (!rst_b)
    a2v_mode && win_r == '0 |=> pk_valid_r && win_r == CNT_W'(PEAK_UNIT_CYC * (int'($past(peak_win_r)) + 1) - 1))
    else $error("peak window length wrong");
endmodule : hvr_timing_a2v_regs

`default_nettype wire

/* File: hvr_timing_a2v_regs_tb.sv */
// hvr_timing_a2v_regs_tb: self-checking bench for the segment-timing and
// audio-to-vibe register block; drives the byte register port directly.
// assumes STEP_CYC 4 and PEAK_UNIT_CYC 20 to keep the run short.
`default_nettype none

module hvr_timing_a2v_regs_tb import hvr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int STEP = 4;
  localparam int PUNIT = 20;
  logic mclk, rst_b, reg_wr, reg_rd, seg_start, closed_loop, a2v_mode, audio_valid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, seg_dur, audio_code, a2v_drive_ceiling, a2v_drive;
  logic signed [7:0] seg_level, wave_max, wave_min;
  logic seg_busy, seg_done, a2v_drive_valid;
  hvr_seg_class_t seg_class;
  logic [8:0] seg_steps;
  logic [1:0] a2v_peak_window, a2v_lowpass_sel;
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;

`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin err_total++; \
  $display("unexpected %s exp %h got %h", nm, exp, got); end end

  hvr_timing_a2v_regs #(.STEP_CYC(STEP), .PEAK_UNIT_CYC(PUNIT)) u_dut (.mclk(mclk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .seg_start(seg_start), .seg_level(seg_level), .seg_dur(seg_dur), .wave_max(wave_max),
    .wave_min(wave_min), .closed_loop(closed_loop), .seg_busy(seg_busy), .seg_done(seg_done),
    .seg_class(seg_class), .seg_steps(seg_steps), .a2v_mode(a2v_mode), .audio_valid(audio_valid),
    .audio_code(audio_code), .a2v_drive_ceiling(a2v_drive_ceiling), .a2v_drive_valid(a2v_drive_valid),
    .a2v_drive(a2v_drive), .a2v_peak_window(a2v_peak_window), .a2v_lowpass_sel(a2v_lowpass_sel));

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run

  // hang guard, well above the longest expected sequence
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      complete_run();
    end
  end

  task automatic do_reset();
    rst_b = 1'b0;
    repeat (2) @(posedge mclk);
    #1 rst_b = 1'b1;
  endtask : do_reset

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge mclk);
    #1 reg_wr = 1'b0;
    // idle edge, so a following call never re-raises the strobe in the same step
    @(posedge mclk);
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge mclk);
    #1 reg_rd = 1'b0;
    `CHK("reg_rdata", e, reg_rdata)
    @(posedge mclk);
    #1;
  endtask : rd

  // reset values of every mapped byte, plus one unmapped address
  task automatic chk_reset_vals();
    logic [7:0] exp_v [8] = '{8'h00, 8'h00, 8'h00, 8'h05, 8'h19, 8'hff, 8'h19, 8'h00};
    for (int i = 0; i < 8; i++)
      rd(8'h0e + 8'(i), exp_v[i]);
    `CHK("peak_window", 2'h1, a2v_peak_window)
    `CHK("lowpass_sel", 2'h1, a2v_lowpass_sel)
  endtask : chk_reset_vals

  // write then read back at once; control byte keeps only its low nibble
  task automatic chk_write_read();
    logic [7:0] d;
    for (int i = 0; i < 8; i++)
    begin
      d = 8'ha5 + 8'(i);
      wr(8'h0e + 8'(i), d);
      rd(8'h0e + 8'(i), (i == 7) ? 8'h00 : (i == 3) ? (d & 8'h0f) : d);
    end
    `CHK("peak_window", 2'h2, a2v_peak_window)
    `CHK("lowpass_sel", 2'h0, a2v_lowpass_sel)
  endtask : chk_write_read

  // one segment: class and steps two cycles on, then busy length
  task automatic seg_run(input logic signed [7:0] lvl, input logic [7:0] dur, input logic cl,
                         input hvr_seg_class_t ec, input logic [8:0] es);
    int cnt;
    cnt = 0;
    seg_start = 1'b1;
    seg_level = lvl;
    seg_dur = dur;
    closed_loop = cl;
    @(posedge mclk);
    #1 seg_start = 1'b0;
    @(posedge mclk);
    #1;
    `CHK("seg_class", ec, seg_class)
    `CHK("seg_steps", es, seg_steps)
    for (int k = 0; k < 2000 && seg_done !== 1'b1; k++)
    begin
      cnt += (seg_busy === 1'b1) ? 1 : 0;
      @(posedge mclk);
      #1;
    end
    `CHK("seg_done", 1'b1, seg_done)
    `CHK("busy_cycles", 32'(es) * STEP, cnt)
    @(posedge mclk);
    #1;
  endtask : seg_run

  // steady audio level; third result judged, window from pulse spacing
  task automatic a2v_case(input logic [1:0] win, input logic [7:0] code, input logic [7:0] full,
                          input logic [7:0] dfl, input logic [7:0] ceil, input logic [7:0] e);
    int t [3];
    int n;
    n = 0;
    wr(ADDR_A2V_CTL, {4'h0, win, 2'h2});
    wr(ADDR_IN_FULL, full);
    wr(ADDR_DRV_FLOOR, dfl);
    a2v_drive_ceiling = ceil;
    audio_code = code;
    audio_valid = 1'b1;
    a2v_mode = 1'b1;
    for (int k = 0; k < 600 && n < 3; k++)
    begin
      @(posedge mclk);
      #1;
      if (a2v_drive_valid === 1'b1)
      begin
        t[n] = k;
        n++;
      end
    end
    `CHK("drive_pulses", 3, n)
    `CHK("a2v_drive", e, a2v_drive)
    `CHK("window_len", (32'(win) + 1) * PUNIT, t[2] - t[1])
    `CHK("peak_window", win, a2v_peak_window)
    a2v_mode = 1'b0;
    audio_valid = 1'b0;
    @(posedge mclk);
    #1;
  endtask : a2v_case

  initial
  begin
    {rst_b, reg_wr, reg_rd, seg_start, closed_loop, a2v_mode, audio_valid} = '0;
    {reg_addr, reg_wdata, seg_dur, audio_code, seg_level} = '0;
    a2v_drive_ceiling = 8'hff;
    wave_max = 8'sd20;
    wave_min = -8'sd20;
    #1;
    do_reset();
    chk_reset_vals();
    seg_run(8'sd10, 8'd3, 1'b0, SEG_POS_SUSTAIN, 9'd3);
    chk_write_read();
    do_reset();
    chk_reset_vals();
    wr(ADDR_POS_OFF, 8'h02);
    wr(ADDR_NEG_OFF, 8'hff);
    wr(ADDR_BRK_OFF, 8'h03);
    seg_run(8'sd10, 8'd3, 1'b0, SEG_POS_SUSTAIN, 9'd5);
    seg_run(8'sd20, 8'd3, 1'b0, SEG_OVERDRIVE, 9'd3);
    seg_run(-8'sd5, 8'd2, 1'b0, SEG_NEG_SUSTAIN, 9'd1);
    seg_run(-8'sd20, 8'd1, 1'b0, SEG_BRAKE, 9'd4);
    seg_run(-8'sd20, 8'd1, 1'b1, SEG_BRAKE, 9'd1);
    wr(ADDR_NEG_OFF, 8'hfb);
    seg_run(-8'sd5, 8'd2, 1'b0, SEG_NEG_SUSTAIN, 9'd0);
    a2v_case(2'h0, 8'h80, 8'hff, 8'h19, 8'hff, 8'h80);
    a2v_case(2'h1, 8'h10, 8'hff, 8'h19, 8'hff, 8'h00);
    a2v_case(2'h2, 8'h20, 8'hff, 8'h40, 8'hff, 8'h40);
    a2v_case(2'h3, 8'h80, 8'h80, 8'h19, 8'hc0, 8'hc0);
    a2v_case(2'h3, 8'h40, 8'h80, 8'h19, 8'hff, 8'h7f);
    complete_run();
  end
endmodule : hvr_timing_a2v_regs_tb

`default_nettype wire
